// [core/adsq_ctrl.sv]
`timescale 1ns/10ps
// Contract
// - Converter halts in stop mode; clearing run and power bits saves current.
// - A result read coinciding with result load is served first, then stored.
// - Mode or channel write at end of conversion wins; no load, no flag.
// - Conversion time counts from sampling start to result, sampling included.
// - Rewriting channel select never clears the done flag.
// - Channel change mid-conversion aborts it; the old result and flag are not set.
// - First result is suspect if run set within 1 us of power or unpowered.
// - Mode or channel writes may leave results undefined; read first.
// - Full result holds 10 bits; upper result holds top 8 bits.
// - After each conversion the next starts at once while run is set.
// - Mode or channel write aborts conversion and restarts if run stays set.
// - Clearing run stops conversion at once; that result is undefined.
module adsq_ctrl
	import adsq_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int SETTLE_CYCLES = SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Software side
	input wire adsq_wr_t wr,
	input wire logic result_rd,
	input wire logic flag_clr,
	input wire logic stop_mode,
	// Comparator from analog front end
	input wire logic cmp_high,
	// Register and status outputs
	output logic [7:0] converter_mode_reg,
	output logic [1:0] channel_select_reg,
	output logic [9:0] result_full_reg,
	output logic [7:0] result_upper_reg,
	output logic conversion_done_flag,
	output logic conversion_done_irq,
	output logic first_suspect,
	output logic sample_on,
	output logic [3:0] analog_input_sel
);
	// Counters are 8 and 16 bits wide
	if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 255) begin : g_bad_sample
		$error("SAMPLE_CYCLES out of range");
	end
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
		$error("SETTLE_CYCLES out of range");
	end

	adsq_state_t state;
	logic [7:0] samp_cnt;
	logic [3:0] bit_idx;
	logic [9:0] sar;
	logic [15:0] settle_cnt;
	logic pend_load;
	logic [9:0] pend_val;
	logic run, pwr, any_wr, done_now, load_now;

	assign run = converter_mode_reg[MODE_RUN_BIT];
	assign pwr = converter_mode_reg[MODE_POWER_BIT];
	assign any_wr = wr.mode_we | wr.chan_we;
	// Completion of the last SAR step
	assign done_now = (state == ADSQ_CONVERT) && (bit_idx == 4'h0)
		&& run && !stop_mode;
	// Write beats completion; read defers the load by one cycle
	assign load_now = (done_now && !any_wr && !result_rd)
		|| (pend_load && !result_rd);

	// Register writes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			converter_mode_reg <= MODE_RESET;
			channel_select_reg <= CHAN_RESET;
		end else begin
			if (wr.mode_we)
				converter_mode_reg <= wr.mode_wdata;
			if (wr.chan_we)
				channel_select_reg <= wr.chan_wdata;
		end
	end

	// Sequencer: sample then ten compare steps, repeating
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ADSQ_IDLE;
			samp_cnt <= 8'h00;
			bit_idx <= 4'h0;
			sar <= RESULT_RESET;
		end else if (!run || stop_mode) begin
			state <= ADSQ_IDLE;
		end else if (any_wr) begin
			state <= ADSQ_SAMPLE;
			samp_cnt <= 8'h00;
		end else begin
			case (state)
			ADSQ_IDLE: begin
				state <= ADSQ_SAMPLE;
				samp_cnt <= 8'h00;
			end
			ADSQ_SAMPLE: begin
				if (samp_cnt == 8'(SAMPLE_CYCLES - 1)) begin
					state <= ADSQ_CONVERT;
					bit_idx <= 4'(RES_BITS - 1);
					sar <= 10'h200;
				end else begin
					samp_cnt <= samp_cnt + 8'h01;
				end
			end
			ADSQ_CONVERT: begin
				if (!cmp_high)
					sar[bit_idx] <= 1'b0;
				if (bit_idx == 4'h0) begin
					state <= ADSQ_SAMPLE;
					samp_cnt <= 8'h00;
				end else begin
					bit_idx <= bit_idx - 4'h1;
					sar[bit_idx - 4'h1] <= 1'b1;
				end
			end
			default: state <= ADSQ_IDLE;
			endcase
		end
	end

	// Deferred load when a read collides with completion
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pend_load <= 1'b0;
			pend_val <= RESULT_RESET;
		end else if (done_now && !any_wr && result_rd) begin
			pend_load <= 1'b1;
			pend_val <= {sar[9:1], cmp_high};
		end else if (load_now) begin
			pend_load <= 1'b0;
		end
	end

	// Result registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			result_full_reg <= RESULT_RESET;
			result_upper_reg <= 8'h00;
		end else if (load_now) begin
			result_full_reg <= pend_load ? pend_val
				: {sar[9:1], cmp_high};
			result_upper_reg <= pend_load ? pend_val[9:2] : sar[9:2];
		end
	end

	// Done flag: set wins over clear; channel writes never clear it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			conversion_done_flag <= 1'b0;
			conversion_done_irq <= 1'b0;
		end else begin
			conversion_done_irq <= load_now;
			if (load_now)
				conversion_done_flag <= 1'b1;
			else if (flag_clr)
				conversion_done_flag <= 1'b0;
		end
	end

	// Power settle tracking for the first-result warning
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			settle_cnt <= 16'h0000;
			first_suspect <= 1'b0;
		end else begin
			if (!pwr)
				settle_cnt <= 16'h0000;
			else if (settle_cnt != 16'(SETTLE_CYCLES))
				settle_cnt <= settle_cnt + 16'h0001;
			if (wr.mode_we && wr.mode_wdata[MODE_RUN_BIT] && !run)
				first_suspect <= !pwr
					|| settle_cnt != 16'(SETTLE_CYCLES);
			else if (load_now)
				first_suspect <= 1'b0;
		end
	end

	// Front-end controls; sample switch off when run clear or stopped, input select off when unpowered or stopped
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sample_on <= 1'b0;
			analog_input_sel <= 4'h0;
		end else begin
			// Follows the next state so the switch opens before bit 9
			sample_on <= run && !stop_mode && (any_wr
				|| state == ADSQ_IDLE
				|| (state == ADSQ_SAMPLE
				&& samp_cnt != 8'(SAMPLE_CYCLES - 1))
				|| (state == ADSQ_CONVERT && bit_idx == 4'h0));
			analog_input_sel <= (pwr && !stop_mode)
				? 4'(4'h1 << channel_select_reg) : 4'h0;
		end
	end

	property p_write_blocks_load;
		@(posedge clk_sys) disable iff (!rst_n)
		(done_now && any_wr && !pend_load) |=> !conversion_done_irq;
	endproperty
	a_write_blocks_load: assert property (p_write_blocks_load)
		else $error("Load despite register write");

	property p_read_defers;
		@(posedge clk_sys) disable iff (!rst_n)
		(done_now && !any_wr && result_rd && !pend_load)
			|=> !conversion_done_irq ##1 (conversion_done_irq || pend_load);
	endproperty
	a_read_defers: assert property (p_read_defers)
		else $error("Read collision not deferred");

	property p_flag_with_load;
		@(posedge clk_sys) disable iff (!rst_n)
		conversion_done_irq |-> conversion_done_flag;
	endproperty
	a_flag_with_load: assert property (p_flag_with_load)
		else $error("Flag not set with load");

	property p_chan_keeps_flag;
		@(posedge clk_sys) disable iff (!rst_n)
		(conversion_done_flag && wr.chan_we && !flag_clr)
			|=> conversion_done_flag;
	endproperty
	a_chan_keeps_flag: assert property (p_chan_keeps_flag)
		else $error("Channel write cleared flag");

	property p_stop_halts;
		@(posedge clk_sys) disable iff (!rst_n)
		(stop_mode || !run) |=> state == ADSQ_IDLE;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("Converter ran while stopped");

	property p_restart;
		@(posedge clk_sys) disable iff (!rst_n)
		(any_wr && run && !stop_mode && !(wr.mode_we
			&& !wr.mode_wdata[MODE_RUN_BIT])) |=> state == ADSQ_SAMPLE;
	endproperty
	a_restart: assert property (p_restart)
		else $error("Write did not restart conversion");

	property p_abort_no_load;
		@(posedge clk_sys) disable iff (!rst_n)
		(state != ADSQ_IDLE && !run && !pend_load)
			|=> !conversion_done_irq [*3];
	endproperty
	a_abort_no_load: assert property (p_abort_no_load)
		else $error("Aborted conversion loaded");

	property p_upper;
		@(posedge clk_sys) disable iff (!rst_n)
		conversion_done_irq |-> result_upper_reg == result_full_reg[9:2];
	endproperty
	a_upper: assert property (p_upper)
		else $error("Upper result mismatch");

	property p_back_to_back;
		@(posedge clk_sys) disable iff (!rst_n)
		(done_now && !any_wr) |=> state == ADSQ_SAMPLE;
	endproperty
	a_back_to_back: assert property (p_back_to_back)
		else $error("Next conversion did not start");

	c_load: cover property (@(posedge clk_sys) conversion_done_irq);
	c_read_clash: cover property (@(posedge clk_sys)
		done_now && result_rd && !any_wr);
	c_write_clash: cover property (@(posedge clk_sys) done_now && any_wr);
	c_suspect: cover property (@(posedge clk_sys) first_suspect);
endmodule

// [core/adsq_pkg.sv]
package adsq_pkg;
	// Mode register field positions
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_POWER_BIT = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [1:0] CHAN_RESET = 2'h0;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	// Timing: clock rate and power-up settle time
	localparam int CLK_MHZ = 100;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SAMPLE_CYC = 8;
	localparam int RES_BITS = 10;

	typedef enum logic [2:0] {
		ADSQ_IDLE = 3'b001,
		ADSQ_SAMPLE = 3'b010,
		ADSQ_CONVERT = 3'b100
	} adsq_state_t;

	// Register write request from software
	typedef struct packed {
		logic mode_we;
		logic [7:0] mode_wdata;
		logic chan_we;
		logic [1:0] chan_wdata;
	} adsq_wr_t;
endpackage

// [sim/adsq_front.sv]
`timescale 1ns/10ps
module adsq_front
	import adsq_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// From converter
	input wire logic sample_on,
	input wire logic [3:0] analog_input_sel,
	// To converter
	output logic cmp_high
);
	logic [9:0] acc;
	logic [9:0] lvl;
	int k = 10;
	// Pin levels held steady while converting
	always_comb begin
		case (analog_input_sel)
			4'h1: lvl = 10'h2a5;
			4'h2: lvl = 10'h15a;
			4'h4: lvl = 10'h3ff;
			4'h8: lvl = 10'h001;
			default: lvl = 10'h000;
		endcase
	end
	// Outside a decision the line toggles so nothing is settled by luck
	assign cmp_high = (k < 10) ? (lvl >= (acc | (10'h200 >> k))) : k[0];
	always @(posedge clk_sys) begin
		if (sample_on) begin
			acc <= 10'h000;
			k <= 0;
		end else if (k < 10) begin
			if (cmp_high)
				acc <= acc | (10'h200 >> k);
			k <= k + 1;
		end else begin
			k <= k ^ 1;
		end
	end
endmodule

// [sim/test_adsq_ctrl.sv]
`timescale 1ns/10ps
module test_adsq_ctrl;
	import adsq_pkg::*;
	localparam int SC = 4;
	localparam int P = SC + 10;
	logic clk_sys = 0;
	logic rst_n = 0;
	adsq_wr_t wr = '0;
	logic result_rd = 0, flag_clr = 0, stop_mode = 0, cmp_high;
	logic [7:0] mode_q, upper;
	logic [1:0] chan_q;
	logic [9:0] full;
	logic flag, irq, suspect, sample_on;
	logic [3:0] sel;
	int failures = 0, n_compared = 0;
	logic [9:0] lv [4] = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001};
	always #5 clk_sys = ~clk_sys;
	adsq_ctrl #(.SAMPLE_CYCLES(SC), .SETTLE_CYCLES(4)) DUT (.clk_sys(clk_sys),
		.rst_n(rst_n), .wr(wr), .result_rd(result_rd), .flag_clr(flag_clr),
		.stop_mode(stop_mode), .cmp_high(cmp_high), .converter_mode_reg(mode_q),
		.channel_select_reg(chan_q), .result_full_reg(full),
		.result_upper_reg(upper), .conversion_done_flag(flag),
		.conversion_done_irq(irq), .first_suspect(suspect),
		.sample_on(sample_on), .analog_input_sel(sel));
	adsq_front far (.clk_sys(clk_sys), .sample_on(sample_on),
		.analog_input_sel(sel), .cmp_high(cmp_high));
	task chk(string nm, logic [9:0] e, logic [9:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wm(logic [7:0] d);
		@(negedge clk_sys) wr.mode_we = 1;
		wr.mode_wdata = d;
		@(negedge clk_sys) wr.mode_we = 0;
	endtask
	// Cycles until irq, bounded; 999 if it never comes
	task wirq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(negedge clk_sys) n++;
		end
		if (n == 200) n = 999;
	endtask
	task t_run;
		int n;
		wm(8'h81);
		chk("suspect", 1, suspect);
		wirq(n);
		chk("full", lv[0], full);
		chk("upper", {2'h0, lv[0][9:2]}, {2'h0, upper});
		chk("flag", 1, flag);
		@(negedge clk_sys) wirq(n);
		chk("period", P - 1, n);
		chk("suspect2", 0, suspect);
	endtask
	task t_chan;
		int n;
		@(negedge clk_sys) wr.chan_we = 1;
		wr.chan_wdata = 2'h2;
		@(negedge clk_sys) wr.chan_we = 0;
		chk("flag_kept", 1, flag);
		chk("chan", 2, chan_q);
		wirq(n);
		chk("chan_wait", P, n);
		chk("restart", lv[2], full);
		chk("sel", 4'h4, sel);
	endtask
	task t_rd;
		repeat (P - 1) @(negedge clk_sys);
		result_rd = 1;
		@(negedge clk_sys) result_rd = 0;
		chk("rd_first", 0, irq);
		@(negedge clk_sys) chk("rd_then", 1, irq);
		chk("rd_full", lv[2], full);
	endtask
	// Clear lands before the completion; the write meets it
	task t_wr;
		int n;
		repeat (P - 4) @(negedge clk_sys);
		flag_clr = 1;
		@(negedge clk_sys) flag_clr = 0;
		wm(8'h81);
		chk("wr_noirq", 0, flag);
		chk("wr_keep", lv[2], full);
		wirq(n);
		chk("wr_wait", P, n);
	endtask
	task t_stop;
		int n;
		wm(8'h01);
		flag_clr = 1;
		@(negedge clk_sys) flag_clr = 0;
		wirq(n);
		chk("stopped", 999, n);
		stop_mode = 1;
		wm(8'h81);
		chk("suspect_ok", 0, suspect);
		@(negedge clk_sys) chk("stop_sel", 0, sel);
		chk("stop_samp", 0, sample_on);
		wirq(n);
		chk("stop_irq", 999, n);
		stop_mode = 0;
		chk("clr", 0, flag);
	endtask
	task final_report;
		$display("failures %0d n_compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		final_report();
	end
	initial begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1;
		chk("mode_rst", 0, mode_q);
		t_run();
		t_chan();
		t_rd();
		t_wr();
		t_stop();
		final_report();
	end
endmodule
